/* File: logic/psb_burst_port.sv */
// Behaviour
// - One 16-bit word per clock, two bytes
// - Command, address, data share data lines
// - Strobe driven in command phase shows refresh
// - Read strobe toggles, data edge aligned
// - Host mask; masked bytes stay unchanged
// - Mask low writes byte, high blocks
// - Strobe marks start of data flow
// - Bursts advance one word per clock
// - Wrapped burst within aligned group, sizes configurable
// - Linear burst runs until chip select rises
// - Burst kind taken from each command
// - Hybrid: one wrap, then linear
// - Burst bit 0 wraps, 1 linear
// - Refresh scheduled internally while bus idle
// - Chip select high ends transfer any time
`include "psb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module psb_burst_port import psb_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic bus_clock_true_in,
  input wire logic cs_n_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  input wire logic data_strobe_mask_in,
  output logic data_strobe_mask_out,
  output logic data_strobe_mask_oe_out,
  input wire logic [1:0] wrap_size_in,
  input wire logic hybrid_in,
  output logic refresh_pending_out,
  output logic refresh_active_out,
  output logic link_busy_out,
  output logic overrun_out
);
  localparam int FW = `PSB_ADDR_W + `PSB_WORD_W + `PSB_MASK_W;
  localparam int NWORDS = 1 << `PSB_ADDR_W;

  function automatic logic [`PSB_ADDR_W-1:0] wrap_mask(
    input psb_wrap_size_t sz
  );
    logic [`PSB_ADDR_W-1:0] m;
    m = `PSB_WRAP_MASK_16B;
    unique case (sz)
      2'h0: m = `PSB_WRAP_MASK_16B;
      2'h1: m = `PSB_WRAP_MASK_32B;
      2'h2: m = `PSB_WRAP_MASK_64B;
      2'h3: m = `PSB_WRAP_MASK_128B;
    endcase
    return m;
  endfunction : wrap_mask

  // ---------------- System clock domain ----------------
  logic [1:0] cs_sync_r;
  logic [15:0] ref_tmr_r;
  logic ref_need_r;
  logic ref_act_r;
  logic [7:0] ref_cnt_r;
  logic ref_tick;
  logic ref_done;
  logic bus_idle;
  logic [2:0] ovf_sync_r;
  logic ovf_tog_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cs_sync_r <= 2'h3;
    end else if (ce_in) begin
      cs_sync_r <= {cs_sync_r[0], cs_n_in};
    end
  end

  assign bus_idle = cs_sync_r[1];
  assign ref_tick = (ref_tmr_r == 16'(`PSB_REF_PERIOD_CYC - 1));
  assign ref_done = ref_act_r && (ref_cnt_r == 8'h00);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ref_tmr_r <= 16'h0000;
    end else if (ce_in) begin
      ref_tmr_r <= ref_tick ? 16'h0000 : ref_tmr_r + 16'h0001;
    end
  end

  // A new tick in the cycle a refresh completes keeps the flag set
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ref_need_r <= 1'b0;
    end else if (ce_in) begin
      if (ref_tick) begin
        ref_need_r <= 1'b1;
      end else if (ref_done) begin
        ref_need_r <= 1'b0;
      end
    end
  end

  // Refresh starts only while chip select is high
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ref_act_r <= 1'b0;
      ref_cnt_r <= 8'h00;
    end else if (ce_in) begin
      if (!ref_act_r && ref_need_r && bus_idle) begin
        ref_act_r <= 1'b1;
        ref_cnt_r <= 8'(`PSB_REF_TIME_CYC - 1);
      end else if (ref_done) begin
        ref_act_r <= 1'b0;
      end else if (ref_act_r) begin
        ref_cnt_r <= ref_cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_sync_r <= 3'h0;
    end else if (ce_in) begin
      ovf_sync_r <= {ovf_sync_r[1:0], ovf_tog_r};
    end
  end

  assign refresh_pending_out = ref_need_r;
  assign refresh_active_out = ref_act_r;
  assign link_busy_out = !bus_idle;
  assign overrun_out = ovf_sync_r[2] ^ ovf_sync_r[1];

  // ---------------- Bus clock domain ----------------
  logic lk_clk_n;
  logic lk_rst;
  logic [1:0] lk_ce_r;
  logic [1:0] lk_need_r;
  logic lk_ce;
  logic lk_need;
  logic [7:0] pos_byte_r;
  logic pos_mask_r;
  psb_state_t state_r;
  logic [7:0] cnt_r;
  logic [1:0] ca_idx_r;
  logic is_read_r;
  logic linear_r;
  logic [`PSB_CA_UCOL_W-1:0] ucol_r;
  logic [`PSB_ADDR_W-1:0] addr_r;
  logic [6:0] beat_r;
  logic [`PSB_WORD_W-1:0] rd_r;
  logic [`PSB_WORD_W-1:0] mem_r [NWORDS];
  logic [7:0] rd_lo_r;
  logic ref_lat_r;
  logic [`PSB_WORD_W-1:0] cur_word;
  logic [`PSB_ADDR_W-1:0] gmask;
  logic [`PSB_ADDR_W-1:0] nxt_addr;
  logic hyb_jump;
  logic rd_load;
  logic [`PSB_ADDR_W-1:0] rd_addr;
  logic wr_beat;
  logic [7:0] lat_load;

  // Chip select high resets the protocol state and stops the transfer
  assign lk_rst = rst_in || cs_n_in;
  assign lk_clk_n = ~bus_clock_true_in;
  assign lk_ce = lk_ce_r[1];
  assign lk_need = lk_need_r[1];

  always_ff @(posedge lk_clk_n or posedge rst_in) begin
    if (rst_in) begin
      lk_ce_r <= 2'h0;
      lk_need_r <= 2'h0;
    end else begin
      lk_ce_r <= {lk_ce_r[0], ce_in};
      lk_need_r <= {lk_need_r[0], ref_need_r};
    end
  end

  // First byte of each clock on the rising edge, second on the falling
  always_ff @(posedge bus_clock_true_in or posedge lk_rst) begin
    if (lk_rst) begin
      pos_byte_r <= 8'h00;
      pos_mask_r <= 1'b1;
    end else if (lk_ce) begin
      pos_byte_r <= dq_in;
      pos_mask_r <= data_strobe_mask_in;
    end
  end

  assign cur_word = {pos_byte_r, dq_in};
  assign gmask = wrap_mask(wrap_size_in);
  assign hyb_jump = hybrid_in && !linear_r &&
                    (beat_r == gmask[6:0]);

  always_comb begin
    if (hyb_jump) begin
      nxt_addr = (addr_r & ~gmask) + gmask + 8'h01;
    end else if (linear_r == `PSB_BURST_LINEAR) begin
      nxt_addr = addr_r + 8'h01;
    end else begin
      nxt_addr = (addr_r & ~gmask) | ((addr_r + 8'h01) & gmask);
    end
  end

  assign lat_load = ref_lat_r ? (`PSB_LAT_CYC << 1) - 8'h01 :
                              `PSB_LAT_CYC - 8'h01;
  assign rd_load = is_read_r && ((state_r == PSB_ST_DATA) ||
                   (state_r == PSB_ST_LAT && cnt_r == 8'h00));
  assign rd_addr = (state_r == PSB_ST_DATA) ? nxt_addr : addr_r;
  assign wr_beat = (state_r == PSB_ST_DATA) && !is_read_r;

  // Command decode, latency and burst sequencing, once per clock
  always_ff @(posedge lk_clk_n or posedge lk_rst) begin
    if (lk_rst) begin
      state_r <= PSB_ST_CA;
      ca_idx_r <= 2'h0;
      cnt_r <= 8'h00;
      is_read_r <= 1'b0;
      linear_r <= `PSB_BURST_WRAP;
      ucol_r <= '0;
      addr_r <= '0;
      beat_r <= 7'h00;
      ref_lat_r <= 1'b0;
    end else if (lk_ce) begin
      unique case (state_r)
        PSB_ST_CA: begin
          ca_idx_r <= ca_idx_r + 2'h1;
          if (ca_idx_r == 2'h0) begin
            is_read_r <= (cur_word[`PSB_CA_RW_BIT] == `PSB_CMD_READ);
            linear_r <= cur_word[`PSB_CA_BURST_BIT];
            ref_lat_r <= lk_need;
          end else if (ca_idx_r == 2'h1) begin
            ucol_r <= cur_word[`PSB_CA_UCOL_W-1:0];
          end else begin
            addr_r <= {ucol_r, cur_word[`PSB_CA_LCOL_W-1:0]};
            cnt_r <= lat_load;
            state_r <= PSB_ST_LAT;
          end
        end
        PSB_ST_LAT: begin
          if (cnt_r == 8'h00) begin
            state_r <= PSB_ST_DATA;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        PSB_ST_DATA: begin
          addr_r <= nxt_addr;
          beat_r <= beat_r + 7'h01;
          if (hyb_jump) begin
            linear_r <= `PSB_BURST_LINEAR;
          end
        end
      endcase
    end
  end

  // Write words pass through the buffer on their way to the array
  psb_stream_if #(.W(FW)) wr_in_if ();
  psb_stream_if #(.W(FW)) wr_out_if ();

  assign wr_in_if.valid = lk_ce && wr_beat && !cs_n_in;
  assign wr_in_if.data = {addr_r, cur_word,
                          pos_mask_r, data_strobe_mask_in};
  // Single-port array: a read beat holds off the drain
  assign wr_out_if.ready = lk_ce && !rd_load;

  psb_fifo #(.W(FW), .D(`PSB_FIFO_DEPTH)) u_wr_fifo (
    .clk_in(lk_clk_n),
    .rst_in(rst_in),
    .ce_in(lk_ce),
    .push_if(wr_in_if.snk),
    .pop_if(wr_out_if.src)
  );

  always_ff @(posedge lk_clk_n or posedge rst_in) begin
    if (rst_in) begin
      ovf_tog_r <= 1'b0;
    end else if (wr_in_if.valid && !wr_in_if.ready) begin
      ovf_tog_r <= !ovf_tog_r;
    end
  end

  // Byte lanes with mask low are written, mask high leave memory alone
  always_ff @(posedge lk_clk_n) begin
    if (wr_out_if.valid && wr_out_if.ready) begin
      for (int b = 0; b < `PSB_MASK_W; b++) begin
        if (!wr_out_if.data[b]) begin
          mem_r[wr_out_if.data[FW-1 -: `PSB_ADDR_W]][b*8 +: 8] <=
            wr_out_if.data[`PSB_MASK_W + b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge lk_clk_n or posedge rst_in) begin
    if (rst_in) begin
      rd_r <= '0;
    end else if (lk_ce && rd_load && !cs_n_in) begin
      rd_r <= mem_r[rd_addr];
    end
  end

  // Low byte is held from the rising edge: rd_r moves on at the falling one
  always_ff @(posedge bus_clock_true_in) begin
    if (lk_ce) begin
      rd_lo_r <= rd_r[7:0];
    end
  end

  // Read bytes follow the bus clock so each rides one strobe transition
  assign dq_out = bus_clock_true_in ? rd_r[15:8] : rd_lo_r;
  assign dq_oe_out = !cs_n_in && is_read_r &&
                     (state_r == PSB_ST_DATA);

  always_comb begin
    data_strobe_mask_out = 1'b0;
    data_strobe_mask_oe_out = 1'b0;
    if (!cs_n_in) begin
      unique case (state_r)
        PSB_ST_CA: begin
          data_strobe_mask_oe_out = 1'b1;
          data_strobe_mask_out = (ca_idx_r == 2'h0) ? lk_need : ref_lat_r;
        end
        PSB_ST_LAT: begin
          data_strobe_mask_oe_out = 1'b1;
        end
        PSB_ST_DATA: begin
          data_strobe_mask_oe_out = is_read_r;
          data_strobe_mask_out = is_read_r && bus_clock_true_in;
        end
      endcase
    end
  end

endmodule : psb_burst_port
`default_nettype wire

/* File: logic/psb_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module psb_fifo import psb_pkg::*; #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  psb_stream_if.snk push_if,
  psb_stream_if.src pop_if
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic do_push;
  logic do_pop;

  // Depth is a power of two; the extra pointer bit tells full from empty
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign push_if.ready = !full;
  assign pop_if.valid = !empty;
  assign pop_if.data = mem_r[rd_ptr_r[AW-1:0]];
  assign do_push = ce_in && push_if.valid && !full;
  assign do_pop = ce_in && pop_if.ready && !empty;

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= push_if.data;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
    end else if (do_push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ptr_r <= '0;
    end else if (do_pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule : psb_fifo
`default_nettype wire

/* File: logic/psb_pkg.sv */
`default_nettype none
package psb_pkg;

  typedef enum logic [1:0] {
    PSB_ST_CA = 2'b00,
    PSB_ST_LAT = 2'b01,
    PSB_ST_DATA = 2'b10
  } psb_state_t;

  typedef logic [1:0] psb_wrap_size_t;

endpackage : psb_pkg
`default_nettype wire

/* File: logic/psb_regs.svh */
`ifndef PSB_REGS_SVH
`define PSB_REGS_SVH

// Command word bit positions (first, second and third command words)
`define PSB_CA_RW_BIT 15
`define PSB_CA_SPACE_BIT 14
`define PSB_CA_BURST_BIT 13
`define PSB_CA_UCOL_W 5
`define PSB_CA_LCOL_W 3

// Burst-kind encoding and the read/write flag
`define PSB_BURST_WRAP 1'b0
`define PSB_BURST_LINEAR 1'b1
`define PSB_CMD_READ 1'b1

// Array shape and buffer depth
`define PSB_ADDR_W 8
`define PSB_WORD_W 16
`define PSB_MASK_W 2
`define PSB_FIFO_DEPTH 4

// Wrap group masks in words: 16, 32, 64 and 128 bytes
`define PSB_WRAP_MASK_16B 8'h07
`define PSB_WRAP_MASK_32B 8'h0f
`define PSB_WRAP_MASK_64B 8'h1f
`define PSB_WRAP_MASK_128B 8'h3f

// Timing
`define PSB_LAT_CYC 8'h06
`define PSB_CLK_PERIOD_NS 10
`define PSB_REF_PERIOD_NS 4000
`define PSB_REF_TIME_NS 60
`define PSB_REF_PERIOD_CYC (`PSB_REF_PERIOD_NS / `PSB_CLK_PERIOD_NS)
`define PSB_REF_TIME_CYC \
  ((`PSB_REF_TIME_NS + `PSB_CLK_PERIOD_NS - 1) / `PSB_CLK_PERIOD_NS)

`endif

/* File: logic/psb_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface psb_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : psb_stream_if
`default_nettype wire

/* File: test/psb_burst_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module psb_burst_port_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic bus_clock_true_in,
  input wire logic cs_n_in,
  input wire logic [7:0] dq_in,
  input wire logic dq_oe_out,
  input wire logic data_strobe_mask_out,
  input wire logic data_strobe_mask_oe_out,
  input wire logic refresh_pending_out,
  input wire logic refresh_active_out,
  input wire logic link_busy_out,
  input wire logic overrun_out
);
  logic [4:0] cyc_r;
  logic rd_r;
  logic ref_r;
  logic [4:0] start;
  // Counts bus cycles of the frame, saturating
  always_ff @(posedge bus_clock_true_in or posedge cs_n_in) begin
    if (cs_n_in) cyc_r <= 5'h00;
    else if (cyc_r != 5'h1f) cyc_r <= cyc_r + 5'h01;
  end
  always_ff @(posedge bus_clock_true_in) begin
    if (cyc_r == 5'h00) rd_r <= dq_in[7];
  end
  always_ff @(negedge bus_clock_true_in) begin
    if (cyc_r == 5'h01) ref_r <= data_strobe_mask_out;
  end
  assign start = ref_r ? 5'h10 : 5'h0a;
  a_ca_strobe_out: assert property (@(negedge bus_clock_true_in)
    disable iff (rst_in || cs_n_in) cyc_r inside {[1:3]} |->
    data_strobe_mask_oe_out && !dq_oe_out) else $error("ca strobe");
  a_ca_strobe_hold: assert property (@(negedge bus_clock_true_in)
    disable iff (rst_in || cs_n_in) cyc_r inside {[2:3]} |->
    data_strobe_mask_out == ref_r) else $error("ca strobe hold");
  a_latency_low: assert property (@(negedge bus_clock_true_in)
    disable iff (rst_in || cs_n_in) cyc_r >= 5'h04 && cyc_r < start |->
    data_strobe_mask_oe_out && !data_strobe_mask_out) else $error("lat");
  a_read_start: assert property (@(negedge bus_clock_true_in)
    disable iff (rst_in || cs_n_in) rd_r && cyc_r == start |->
    dq_oe_out ##1 dq_oe_out) else $error("read start");
  a_write_mask_in: assert property (@(negedge bus_clock_true_in)
    disable iff (rst_in || cs_n_in) !rd_r && cyc_r >= start |->
    !data_strobe_mask_oe_out && !dq_oe_out) else $error("write oe");
  a_idle_release: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) cs_n_in |-> !dq_oe_out && !data_strobe_mask_oe_out)
    else $error("idle drive");
  a_strobe_clock: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) dq_oe_out |-> data_strobe_mask_oe_out &&
    data_strobe_mask_out == bus_clock_true_in) else $error("strobe");
  a_busy_sync: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) !cs_n_in [*3] |-> link_busy_out)
    else $error("busy");
  a_refresh_len: assert property (@(posedge clk_sys_in)
    disable iff (rst_in || !ce_in) $rose(refresh_active_out) |->
    refresh_active_out [*6] ##1 !refresh_active_out) else $error("ref len");
  a_refresh_cause: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) $rose(refresh_active_out) |->
    $past(refresh_pending_out)) else $error("ref cause");
  a_no_overrun: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) !overrun_out) else $error("overrun");
  c_ref_lat: cover property (@(negedge bus_clock_true_in)
    ref_r && cyc_r == 5'h10 && !cs_n_in);
  c_write: cover property (@(negedge bus_clock_true_in)
    !rd_r && cyc_r == 5'h0a && !cs_n_in);
  c_refresh: cover property (@(posedge clk_sys_in) $rose(refresh_active_out));
endmodule : psb_burst_port_asserts
bind psb_burst_port psb_burst_port_asserts u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
  .bus_clock_true_in(bus_clock_true_in), .cs_n_in(cs_n_in), .dq_in(dq_in),
  .dq_oe_out(dq_oe_out), .data_strobe_mask_out(data_strobe_mask_out),
  .data_strobe_mask_oe_out(data_strobe_mask_oe_out),
  .refresh_pending_out(refresh_pending_out),
  .refresh_active_out(refresh_active_out), .link_busy_out(link_busy_out),
  .overrun_out(overrun_out));
`default_nettype wire

/* File: test/psb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psb_host_model (
  output logic ck_out,
  output logic cs_n_out,
  output logic [7:0] dq_out,
  output logic msk_out,
  input wire logic [7:0] dq_in,
  input wire logic msk_in
);
  logic [15:0] wd [64];
  logic [1:0] wm [64];
  logic [15:0] rd [128];
  logic ref_seen;
  initial begin
    ck_out = 1'b0;
    cs_n_out = 1'b1;
    dq_out = 8'h00;
    msk_out = 1'b0;
    ref_seen = 1'b0;
  end
  // Data is set a quarter cycle before each clock edge
  task automatic half(input logic [7:0] b, input logic m, input logic lvl);
    dq_out = b;
    msk_out = m;
    #3.75 ck_out = lvl;
    #3.75;
  endtask : half
  task automatic cyc(input logic [15:0] w, input logic [1:0] m,
                     output logic [15:0] r, output logic s);
    half(w[15:8], m[1], 1'b1);
    r[15:8] = dq_in;
    half(w[7:0], m[0], 1'b0);
    r[7:0] = dq_in;
    s = msk_in;
  endtask : cyc
  task automatic idle(input int n);
    logic [15:0] r;
    logic s;
    repeat (n) cyc(~{dq_out, dq_out}, {~msk_out, msk_out}, r, s);
  endtask : idle
  task automatic xfer(input logic rdn, input logic lin, input logic [7:0] a,
                      input int n);
    logic [15:0] r;
    logic s;
    cs_n_out = 1'b0;
    #3.75;
    cyc({rdn, 1'b0, lin, 13'h0000}, 2'b00, r, s);
    ref_seen = s;
    cyc({11'h000, a[7:3]}, 2'b00, r, s);
    cyc({13'h0000, a[2:0]}, 2'b00, r, s);
    idle(ref_seen ? 12 : 6);
    for (int i = 0; i < n; i++) begin
      if (rdn) cyc(~{dq_out, dq_out}, {~msk_out, msk_out}, r, s);
      else cyc(wd[i], wm[i], r, s);
      rd[i] = r;
    end
    #3.75 cs_n_out = 1'b1;
    #7.5;
  endtask : xfer
endmodule : psb_host_model
`default_nettype wire

/* File: test/test_psb_burst_port.sv */
`timescale 1ns/1ps
`default_nettype none
module test_psb_burst_port;
  logic clk_sys, rst, ce, ck, cs_n, h_m, m_o, m_oe, m_w, hyb;
  logic dq_oe, r_pend, r_act, busy, ovr;
  logic [7:0] h_dq, dq_o, dq_w;
  logic [1:0] wsz;
  logic [15:0] mem [64];
  int errors, compares;
  assign dq_w = dq_oe ? dq_o : h_dq;
  assign m_w = m_oe ? m_o : h_m;
  psb_host_model host (.ck_out(ck), .cs_n_out(cs_n), .dq_out(h_dq),
    .msk_out(h_m), .dq_in(dq_w), .msk_in(m_w));
  psb_burst_port dut (.clk_sys_in(clk_sys), .rst_in(rst), .ce_in(ce),
    .bus_clock_true_in(ck), .cs_n_in(cs_n), .dq_in(dq_w), .dq_out(dq_o),
    .dq_oe_out(dq_oe), .data_strobe_mask_in(m_w),
    .data_strobe_mask_out(m_o), .data_strobe_mask_oe_out(m_oe),
    .wrap_size_in(wsz), .hybrid_in(hyb), .refresh_pending_out(r_pend),
    .refresh_active_out(r_act), .link_busy_out(busy), .overrun_out(ovr));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic wait_act(input logic v);
    int k;
    for (k = 0; k < 2000 && r_act !== v; k++) @(posedge clk_sys);
    if (k == 2000) begin
      errors++;
      summarize();
    end
  endtask : wait_act
  // Walks the expected address order of the burst
  task automatic t_read(input logic lin, input logic [7:0] a, input int n);
    logic [7:0] m, ad;
    logic lk;
    m = (8'h08 << wsz) - 8'h01;
    ad = a;
    lk = lin;
    host.xfer(1'b1, lin, a, n);
    for (int i = 0; i < n; i++) begin
      check(host.rd[i], mem[ad[5:0]]);
      if (lk) ad = ad + 8'h01;
      else if (hyb && i == int'(m)) begin
        ad = (a & ~m) + m + 8'h01;
        lk = 1'b1;
      end else ad = (ad & ~m) | ((ad + 8'h01) & m);
    end
  endtask : t_read
  task automatic t_fill();
    for (int i = 0; i < 64; i++) begin
      host.wd[i] = {8'(i) ^ 8'h5c, 8'(i)};
      host.wm[i] = 2'b00;
      mem[i] = host.wd[i];
    end
    host.xfer(1'b0, 1'b1, 8'h00, 64);
    t_read(1'b1, 8'h00, 64);
  endtask : t_fill
  task automatic t_mask();
    for (int i = 0; i < 4; i++) begin
      host.wd[i] = 16'h5a00 | 16'(i);
      host.wm[i] = 2'(i + 1);
      if (!host.wm[i][1]) mem[32 + i][15:8] = host.wd[i][15:8];
      if (!host.wm[i][0]) mem[32 + i][7:0] = host.wd[i][7:0];
    end
    host.xfer(1'b0, 1'b1, 8'h20, 4);
    t_read(1'b1, 8'h20, 6);
  endtask : t_mask
  task automatic t_wrap();
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_sys) wsz = 2'(s);
      t_read(1'b0, 8'h0d, (8 << s) + 2);
    end
    @(negedge clk_sys) wsz = 2'b00;
    hyb = 1'b1;
    t_read(1'b0, 8'h0d, 18);
    @(negedge clk_sys) hyb = 1'b0;
    t_read(1'b1, 8'h0d, 4);
  endtask : t_wrap
  task automatic t_refresh();
    wait_act(1'b0);
    wait_act(1'b1);
    @(negedge clk_sys) ce = 1'b0;
    repeat (20) @(posedge clk_sys);
    check({15'h0000, r_act}, 16'h0001);
    @(negedge clk_sys) ce = 1'b1;
    repeat (370) @(posedge clk_sys);
    host.xfer(1'b1, 1'b1, 8'h00, 40);
    @(negedge clk_sys);
    check({15'h0000, r_pend}, 16'h0001);
    t_read(1'b1, 8'h05, 3);
    check({15'h0000, host.ref_seen}, 16'h0001);
    wait_act(1'b1);
    wait_act(1'b0);
    @(negedge clk_sys);
    check({15'h0000, r_pend}, 16'h0000);
  endtask : t_refresh
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wsz = 2'b00;
    hyb = 1'b0;
    errors = 0;
    compares = 0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    #2.3 host.idle(3);
    t_fill();
    t_mask();
    t_wrap();
    t_refresh();
    summarize();
  end
endmodule : test_psb_burst_port
`default_nettype wire
